// File: rtl/clk_ctrl_pkg.sv
// Purpose: Shared constants and types for the main clock controller
// Assumes: One 8-bit control/status register plus small interrupt registers
// Notes:   Periods are counted in oscillator clock cycles
package clk_ctrl_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h2e;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h41;
  localparam logic [7:0] OFF_POWER_MODE  = 8'h42;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  // Field positions
  localparam int unsigned BIT_FLAG    = 0;
  localparam int unsigned BIT_IEN     = 1;
  localparam int unsigned BIT_TB_LO   = 2;
  localparam int unsigned BIT_SMS     = 4;
  localparam int unsigned BIT_CP_LO   = 5;
  localparam int unsigned BIT_CLK_OUT = 7;
  // Timebase periods in oscillator cycles
  localparam logic [17:0] TB_PERIOD_0 = 18'd16000;
  localparam logic [17:0] TB_PERIOD_1 = 18'd32000;
  localparam logic [17:0] TB_PERIOD_2 = 18'd80000;
  localparam logic [17:0] TB_PERIOD_3 = 18'd200000;
  localparam int unsigned SLOW_DIV_W = 4;
  typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_ACTIVE_HALT, PM_HALT} power_mode_t;
  // Register image of the control/status word
  typedef struct packed {
    logic       clock_out_select;
    logic [1:0] slow_divider_select;
    logic       slow_mode_select;
    logic [1:0] timebase_select;
    logic       timebase_irq_enable;
    logic       timebase_irq_flag;
  } ctrl_status_t;
endpackage

// File: rtl/clock_ctrl_timebase.sv
// Purpose: Main clock controller: CPU prescaler, clock-out, real-time base
// Assumes: clock is the oscillator clock; power mode comes from the core
// Notes:   CPU clock is delivered as a one-cycle enable pulse
// Notes on behaviour
// RL1: In slow mode codes 00..11 of the slow divider give oscillator/2, /4, /8 or /16.
// RL2: Slow mode select 0 gives full oscillator rate, 1 applies the slow divider.
// RL3: Clock-out select 1 routes the oscillator clock onto the port pin, 0 frees it; here the pin toggles at half the oscillator rate.
// RL4: Timebase codes 00..11 give periods of 16000, 32000, 80000 or 200000 cycles.
// RL5: A new timebase choice takes effect only when the running period ends.
// RL6: The timebase flag is set each time the selected period completes.
// RL7: Reading the control/status register clears the flag; nothing else does.
// RL8: An interrupt request needs the flag, the enable bit and no CPU mask.
// RL9: With the enable bit set a halt instruction enters active halt, not halt.
// RL10: In wait mode the block runs unchanged and its interrupt exits wait.
// RL11: In active halt the counter runs, registers freeze, the interrupt wakes.
// RL12: In halt both counter and registers freeze and the timebase cannot wake.
// RL13: Reset clears every control/status bit.
// RL14: Software must avoid read-modify-write bit instructions on that register.
// RL15: The counter restarts from zero at the period end without software help.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_timebase
  import clk_ctrl_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              cpu_irq_masked,
  input  wire logic              halt_exec,
  input  wire logic              wait_exec,
  input  wire logic              ext_wakeup,
  output logic                   cpu_clk_en,
  output logic                   clk_out_enable,
  output logic                   clk_out_level,
  output logic                   timebase_irq,
  output logic                   wakeup,
  output logic                   irq
);
  ctrl_status_t ctrl_r;
  power_mode_t  mode_r;
  logic [1:0]   tb_active_r;
  logic [17:0]  tb_count_r;
  logic [SLOW_DIV_W-1:0] div_r;
  logic [2:0]   ev_status_r;
  logic [2:0]   ev_mask_r;
  logic         clk_out_r;
  logic         period_end;
  logic         regs_live;
  logic         count_live;
  logic         rd_ctrl;
  logic         ext_s1_r;
  logic         ext_s2_r;

  // Period length for a timebase code
  function automatic logic [17:0] tb_period(input logic [1:0] sel);
    case (sel)
      2'b00:   tb_period = TB_PERIOD_0;
      2'b01:   tb_period = TB_PERIOD_1;
      2'b10:   tb_period = TB_PERIOD_2;
      default: tb_period = TB_PERIOD_3;
    endcase
  endfunction

  // Wake pin from outside the clock domain
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_wakeup;
      ext_s2_r <= ext_s1_r;
    end
  end

  assign regs_live  = (mode_r == PM_RUN) || (mode_r == PM_WAIT); // RL11 RL12
  assign count_live = (mode_r != PM_HALT); // RL10 RL11 RL12
  assign period_end = count_live && (tb_count_r == tb_period(tb_active_r) - 18'd1);
  assign rd_ctrl    = rd_en && (addr == OFF_CTRL_STATUS) && regs_live;

  // Power mode tracking; a timebase event only wakes from wait or active halt
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_r <= PM_RUN;
    end else begin
      case (mode_r)
        PM_RUN: begin
          if (halt_exec) begin
            mode_r <= ctrl_r.timebase_irq_enable ? PM_ACTIVE_HALT : PM_HALT; // RL9
          end else if (wait_exec) begin
            mode_r <= PM_WAIT;
          end
        end
        PM_WAIT: begin
          if (period_end || ext_s2_r) mode_r <= PM_RUN; // RL10
        end
        PM_ACTIVE_HALT: begin
          if (period_end || ext_s2_r) mode_r <= PM_RUN; // RL11
        end
        default: begin
          if (ext_s2_r) mode_r <= PM_RUN; // RL12
        end
      endcase
    end
  end

  // Control/status register; set of the flag beats the read clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= ctrl_status_t'(CTRL_RESET); // RL13
    end else if (regs_live) begin
      if (wr_en && addr == OFF_CTRL_STATUS) begin
        ctrl_r.clock_out_select    <= wdata[BIT_CLK_OUT];
        ctrl_r.slow_divider_select <= wdata[BIT_CP_LO +: 2];
        ctrl_r.slow_mode_select    <= wdata[BIT_SMS];
        ctrl_r.timebase_select     <= wdata[BIT_TB_LO +: 2];
        ctrl_r.timebase_irq_enable <= wdata[BIT_IEN];
      end
      if (period_end) begin
        ctrl_r.timebase_irq_flag <= 1'b1; // RL6
      end else if (rd_ctrl) begin
        ctrl_r.timebase_irq_flag <= 1'b0; // RL7
      end
    end else if (period_end) begin
      ctrl_r.timebase_irq_flag <= 1'b1; // RL11
    end
  end

  // Timebase counter; selection latched only at the period boundary
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tb_count_r  <= 18'd0;
      tb_active_r <= 2'b00;
    end else if (count_live) begin
      if (period_end) begin
        tb_count_r  <= 18'd0; // RL15
        tb_active_r <= ctrl_r.timebase_select; // RL5
      end else begin
        tb_count_r <= tb_count_r + 18'd1; // RL4
      end
    end
  end

  // CPU clock enable from the slow prescaler
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_r      <= '0;
      cpu_clk_en <= 1'b0;
    end else begin
      div_r <= div_r + 1'b1;
      if (!ctrl_r.slow_mode_select) begin
        cpu_clk_en <= 1'b1; // RL2
      end else begin
        case (ctrl_r.slow_divider_select) // RL1
          2'b00:   cpu_clk_en <= (div_r[0]   == 1'b1);
          2'b01:   cpu_clk_en <= (div_r[1:0] == 2'b11);
          2'b10:   cpu_clk_en <= (div_r[2:0] == 3'b111);
          default: cpu_clk_en <= (div_r      == 4'hf);
        endcase
      end
    end
  end

  // Clock out as a toggle at half rate; a register keeps the pin glitch free
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clk_out_r <= 1'b0;
    end else if (ctrl_r.clock_out_select) begin
      clk_out_r <= ~clk_out_r; // RL3
    end else begin
      clk_out_r <= 1'b0;
    end
  end
  assign clk_out_level  = clk_out_r;
  assign clk_out_enable = ctrl_r.clock_out_select; // RL3

  // Interrupt glue: sticky events (period, wake, read clear), write-one clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ev_status_r <= 3'b000;
      ev_mask_r   <= 3'b000;
    end else begin
      if (wr_en && addr == OFF_IRQ_MASK) ev_mask_r <= wdata[2:0];
      ev_status_r <= (ev_status_r & ~((wr_en && addr == OFF_IRQ_STATUS) ? wdata[2:0] : 3'b000))
                     | {rd_ctrl, (mode_r != PM_RUN) && (period_end || ext_s2_r), period_end};
    end
  end
  assign irq = |(ev_status_r & ev_mask_r);

  assign timebase_irq = ctrl_r.timebase_irq_flag && ctrl_r.timebase_irq_enable
                        && !cpu_irq_masked; // RL8
  assign wakeup = (mode_r != PM_RUN) && (mode_r != PM_HALT) && period_end; // RL10 RL11

  // Read data, one cycle later; unmapped reads zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (rd_en) begin
      if (addr == OFF_CTRL_STATUS) rdata <= ctrl_r;
      else if (addr == OFF_IRQ_STATUS) rdata <= {5'h00, ev_status_r};
      else if (addr == OFF_IRQ_MASK) rdata <= {5'h00, ev_mask_r};
      else if (addr == OFF_POWER_MODE) rdata <= {6'h00, mode_r};
      else rdata <= '0;
    end
  end

  // Checks
  a_flag_on_end: assert property (@(posedge clock) disable iff (!rstn)
    period_end |=> ctrl_r.timebase_irq_flag) else $error("flag not set"); // RL6
  a_read_clears: assert property (@(posedge clock) disable iff (!rstn)
    rd_ctrl && !period_end |=> !ctrl_r.timebase_irq_flag) else $error("flag not cleared"); // RL7
  a_irq_gating: assert property (@(posedge clock) disable iff (!rstn)
    timebase_irq |-> ctrl_r.timebase_irq_flag && ctrl_r.timebase_irq_enable) else $error("bad irq"); // RL8
  a_halt_choice: assert property (@(posedge clock) disable iff (!rstn)
    mode_r == PM_RUN && halt_exec && ctrl_r.timebase_irq_enable |=> mode_r == PM_ACTIVE_HALT)
    else $error("no active halt"); // RL9
  a_halt_frozen: assert property (@(posedge clock) disable iff (!rstn)
    mode_r == PM_HALT && $past(mode_r) == PM_HALT |-> $stable(tb_count_r)) else $error("counter ran"); // RL12
  a_ahalt_regs: assert property (@(posedge clock) disable iff (!rstn)
    mode_r == PM_ACTIVE_HALT |=> $stable(ctrl_r.timebase_select)) else $error("regs moved"); // RL11
  a_sel_defer: assert property (@(posedge clock) disable iff (!rstn)
    !period_end |=> $stable(tb_active_r)) else $error("early select"); // RL5
  a_count_wrap: assert property (@(posedge clock) disable iff (!rstn)
    period_end |=> tb_count_r == 18'd0) else $error("no wrap"); // RL15
  a_full_speed: assert property (@(posedge clock) disable iff (!rstn) // RL2
    !ctrl_r.slow_mode_select ##1 !ctrl_r.slow_mode_select ##1 !ctrl_r.slow_mode_select |-> cpu_clk_en)
    else $error("slow");
  a_div_two: assert property (@(posedge clock) disable iff (!rstn)
    ctrl_r.slow_mode_select && ctrl_r.slow_divider_select == 2'b00 && cpu_clk_en
    |=> !cpu_clk_en) else $error("div2"); // RL1
  a_clk_out_off: assert property (@(posedge clock) disable iff (!rstn)
    !ctrl_r.clock_out_select |=> !clk_out_level) else $error("pin driven"); // RL3
  c_period: cover property (@(posedge clock) disable iff (!rstn) period_end);
  c_ahalt_wake: cover property (@(posedge clock) disable iff (!rstn)
    mode_r == PM_ACTIVE_HALT && period_end);
  c_slow16: cover property (@(posedge clock) disable iff (!rstn)
    ctrl_r.slow_mode_select && ctrl_r.slow_divider_select == 2'b11 && cpu_clk_en);
  c_wait_wake: cover property (@(posedge clock) disable iff (!rstn)
    mode_r == PM_WAIT && period_end);

  // Checker helpers: read only by the assertions below. They keep their own
  // count of CPU clock spacing so a broken prescaler cannot hide behind itself.
  localparam logic [4:0] SLOW_LEN_2     = 5'd2;
  localparam logic [4:0] SLOW_LEN_4     = 5'd4;
  localparam logic [4:0] SLOW_LEN_8     = 5'd8;
  localparam logic [4:0] SLOW_LEN_16    = 5'd16;
  localparam logic [1:0] PULSES_SETTLED = 2'd3;

  // Spacing of CPU clock pulses for a slow divider code
  function automatic logic [4:0] slow_len(input logic [1:0] sel);
    case (sel)
      2'b00:   slow_len = SLOW_LEN_2;
      2'b01:   slow_len = SLOW_LEN_4;
      2'b10:   slow_len = SLOW_LEN_8;
      default: slow_len = SLOW_LEN_16;
    endcase
  endfunction

  logic [4:0] cpu_gap_r;
  logic [1:0] cpu_seen_r;

  // Cycles since the last CPU pulse; the first pulses after a control write
  // may still carry the old spacing, so checking waits for three of them
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cpu_gap_r  <= '0;
      cpu_seen_r <= '0;
    end else begin
      if (cpu_clk_en) begin
        cpu_gap_r <= '0;
      end else begin
        cpu_gap_r <= cpu_gap_r + 5'd1;
      end
      if (wr_en && addr == OFF_CTRL_STATUS) begin
        cpu_seen_r <= '0;
      end else if (cpu_clk_en && cpu_seen_r != PULSES_SETTLED) begin
        cpu_seen_r <= cpu_seen_r + 2'd1;
      end
    end
  end

  // Power mode exits: the timebase ends wait and active halt, never halt
  a_wait_exit: assert property (@(posedge clock) disable iff (!rstn) // RL10
    mode_r == PM_WAIT && period_end |=> mode_r == PM_RUN)
    else $error("wait not left");
  a_ahalt_exit: assert property (@(posedge clock) disable iff (!rstn) // RL11
    mode_r == PM_ACTIVE_HALT && period_end |=> mode_r == PM_RUN)
    else $error("active halt not left");
  a_halt_no_tb: assert property (@(posedge clock) disable iff (!rstn) // RL12
    mode_r == PM_HALT && !ext_s2_r |=> mode_r == PM_HALT)
    else $error("halt left without wake");
  a_ext_resume: assert property (@(posedge clock) disable iff (!rstn) // RL12
    mode_r != PM_RUN && ext_s2_r |=> mode_r == PM_RUN)
    else $error("wake pin ignored");

  // Halt entry without the enable bit, and frozen registers in halt
  // A control/status write that lands in halt is lost, not queued for the wake
  a_halt_plain: assert property (@(posedge clock) disable iff (!rstn) // RL9
    mode_r == PM_RUN && halt_exec && !ctrl_r.timebase_irq_enable |=> mode_r == PM_HALT)
    else $error("no full halt");
  a_halt_regs: assert property (@(posedge clock) disable iff (!rstn) // RL12
    mode_r == PM_HALT |=> $stable(ctrl_r))
    else $error("regs moved in halt");

  // Flag is only set by the period end and only cleared by a live read
  a_flag_hold: assert property (@(posedge clock) disable iff (!rstn) // RL7
    ctrl_r.timebase_irq_flag && !rd_ctrl |=> ctrl_r.timebase_irq_flag)
    else $error("flag lost");
  a_flag_no_sw: assert property (@(posedge clock) disable iff (!rstn) // RL6
    !ctrl_r.timebase_irq_flag && !period_end |=> !ctrl_r.timebase_irq_flag)
    else $error("flag set without period end");
  a_ahalt_read: assert property (@(posedge clock) disable iff (!rstn) // RL11
    mode_r == PM_ACTIVE_HALT && rd_en && addr == OFF_CTRL_STATUS && ctrl_r.timebase_irq_flag
    |=> ctrl_r.timebase_irq_flag) else $error("frozen flag cleared");

  // Request gating by the CPU mask
  a_irq_masked: assert property (@(posedge clock) disable iff (!rstn) // RL8
    cpu_irq_masked |-> !timebase_irq)
    else $error("masked request");
  a_irq_request: assert property (@(posedge clock) disable iff (!rstn) // RL8
    ctrl_r.timebase_irq_flag && ctrl_r.timebase_irq_enable && !cpu_irq_masked |-> timebase_irq)
    else $error("request missing");

  // Counter range, deferred selection and wake pulse
  a_count_bound: assert property (@(posedge clock) disable iff (!rstn) // RL4
    tb_count_r < tb_period(tb_active_r))
    else $error("count beyond period");
  a_sel_latch: assert property (@(posedge clock) disable iff (!rstn) // RL5
    period_end |=> tb_active_r == $past(ctrl_r.timebase_select))
    else $error("selection not taken");
  a_wake_pulse: assert property (@(posedge clock) disable iff (!rstn) // RL10
    mode_r == PM_WAIT && period_end |-> wakeup)
    else $error("no wake pulse");

  // Clock-out toggles every cycle while selected; prescaler spacing in slow mode
  a_clk_out_runs: assert property (@(posedge clock) disable iff (!rstn) // RL3
    ctrl_r.clock_out_select ##1 ctrl_r.clock_out_select |-> $changed(clk_out_level))
    else $error("clock out stuck");
  a_slow_spacing: assert property (@(posedge clock) disable iff (!rstn) // RL1
    ctrl_r.slow_mode_select && cpu_clk_en && cpu_seen_r == PULSES_SETTLED
    |-> cpu_gap_r == slow_len(ctrl_r.slow_divider_select) - 5'd1) else $error("slow spacing");
endmodule
`default_nettype wire

// File: sim/clock_out_sink.sv
// Purpose: Model of an external device fed by the clock-out pin
// Assumes: Pin level seen only while the alternate function drives it
// Notes:   Counts level changes; a free pin shows no clock at all
`timescale 1ns/1ps
`default_nettype none
module clock_out_sink (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clk_out_enable,
  input  wire logic        clk_out_level,
  output logic      [15:0] toggles
);
  logic last_r;

  // Edge counter; a freed pin is ignored, not trusted to hold a level
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      toggles <= 16'h0000;
      last_r  <= 1'b0;
    end else if (clk_out_enable) begin
      last_r <= clk_out_level;
      if (clk_out_level !== last_r) toggles <= toggles + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: sim/clock_ctrl_timebase_bench.sv
// Purpose: Self-checking bench for the main clock controller
// Assumes: Full period counts, so timebase tests take tens of thousands of cycles
// Notes:   Register bus driven right after rising edges
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_timebase_bench;
  import clk_ctrl_pkg::*;
  logic        clock, rstn, wr_en, rd_en, cpu_irq_masked, halt_exec, wait_exec, ext_wakeup;
  logic [7:0]  addr, wdata, rdata, got;
  logic        cpu_clk_en, clk_out_enable, clk_out_level, timebase_irq, wakeup, irq;
  logic [15:0] toggles, t1;
  int          bad_count, total_checks, cycles, n, t0, wake_seen;

  clock_ctrl_timebase dut_u (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .cpu_irq_masked(cpu_irq_masked), .halt_exec(halt_exec),
    .wait_exec(wait_exec), .ext_wakeup(ext_wakeup), .cpu_clk_en(cpu_clk_en),
    .clk_out_enable(clk_out_enable), .clk_out_level(clk_out_level), .timebase_irq(timebase_irq),
    .wakeup(wakeup), .irq(irq));
  clock_out_sink sink_u (.clock(clock), .rstn(rstn), .clk_out_enable(clk_out_enable),
    .clk_out_level(clk_out_level), .toggles(toggles));

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Cycle stamp and hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (wakeup === 1'b1) wake_seen <= wake_seen + 1;
    if (cycles > 100000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      bad_count = bad_count + 1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // Read data is registered at the edge that samples the strobe and holds until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 got = rdata;
  endtask

  // Bounded wait for the level interrupt, sampled after edge updates
  task automatic wait_tb_irq();
    n = 0;
    do begin
      @(posedge clock);
      #1 n = n + 1;
    end while (timebase_irq !== 1'b1 && n < 40000);
    check("timebase irq seen", 16'h0001, {15'h0000, timebase_irq});
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {rstn, wr_en, rd_en, cpu_irq_masked, halt_exec, wait_exec, ext_wakeup} = 7'h00;
    {addr, wdata} = 16'h0000;
    {bad_count, total_checks, cycles, wake_seen} = '0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rd(OFF_CTRL_STATUS); check("ctrl reset", {8'h00, CTRL_RESET}, {8'h00, got});
    rd(8'h55); check("unmapped read", 16'h0000, {8'h00, got});
    // Slow divider codes then normal speed; 64 cycles hold whole periods
    for (int c = 0; c < 5; c++) begin
      wr(OFF_CTRL_STATUS, (c < 4) ? {1'b0, 2'(c), 1'b1, 4'h0} : 8'h00);
      repeat (20) @(posedge clock);
      n = 0;
      repeat (64) begin
        @(posedge clock);
        #1 if (cpu_clk_en === 1'b1) n = n + 1;
      end
      check("cpu clock pulses", (c < 4) ? 16'(64 >> (c + 1)) : 16'd64, 16'(n));
    end
    // Clock-out on, then pin freed
    wr(OFF_CTRL_STATUS, 8'h80);
    repeat (4) @(posedge clock);
    t1 = toggles;
    repeat (40) @(posedge clock);
    check("clock out toggles", 16'd40, toggles - t1);
    wr(OFF_CTRL_STATUS, 8'h00);
    #1 check("clock out free", 16'h0000, {15'h0000, clk_out_enable});
    // First period end, flag clear by read, status W1C
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_CTRL_STATUS, 8'h02);
    wait_tb_irq();
    t0 = cycles;
    check("irq follows flag", 16'h0001, {15'h0000, irq});
    rd(OFF_CTRL_STATUS); check("flag set", 16'h0001, {15'h0000, got[0]});
    check("flag cleared by read", 16'h0000, {15'h0000, timebase_irq});
    rd(OFF_IRQ_STATUS); check("period status", 16'h0001, {15'h0000, got[0]});
    wr(OFF_IRQ_STATUS, 8'h07);
    rd(OFF_IRQ_STATUS); check("status cleared", 16'h0000, {15'h0000, got[0]});
    #1 check("irq cleared", 16'h0000, {15'h0000, irq});
    // Period change mid-run must wait for the running period
    wr(OFF_CTRL_STATUS, 8'h06);
    @(posedge clock);
    wait_exec <= 1'b1;
    @(posedge clock);
    wait_exec <= 1'b0;
    wait_tb_irq();
    check("period kept", 16'd16000, 16'(cycles - t0));
    check("wait wake pulse", 16'd1, 16'(wake_seen));
    rd(OFF_POWER_MODE); check("wait left", 16'h0000, {8'h00, got});
    t0 = cycles;
    rd(OFF_CTRL_STATUS);
    cpu_irq_masked <= 1'b1;
    while (cycles < t0 + 31990) @(posedge clock);
    rd(OFF_CTRL_STATUS); check("flag early", 16'h0000, {15'h0000, got[0]});
    while (cycles < t0 + 32005) @(posedge clock);
    #1 check("masked request", 16'h0000, {15'h0000, timebase_irq});
    rd(OFF_CTRL_STATUS); check("new period", 16'h0001, {15'h0000, got[0]});
    // Halt with enable set gives active halt; writes are frozen
    @(posedge clock);
    halt_exec <= 1'b1;
    @(posedge clock);
    halt_exec <= 1'b0;
    rd(OFF_POWER_MODE); check("active halt", 16'h0002, {8'h00, got});
    wr(OFF_CTRL_STATUS, 8'h80);
    ext_wakeup <= 1'b1;
    repeat (8) @(posedge clock);
    ext_wakeup <= 1'b0;
    rd(OFF_CTRL_STATUS); check("frozen ctrl", 16'h0006, {8'h00, got & 8'hfe});
    // Enable off, so halt is the full one and only the pin wakes it
    wr(OFF_CTRL_STATUS, 8'h00);
    @(posedge clock);
    halt_exec <= 1'b1;
    @(posedge clock);
    halt_exec <= 1'b0;
    rd(OFF_POWER_MODE); check("full halt", 16'h0003, {8'h00, got});
    ext_wakeup <= 1'b1;
    repeat (8) @(posedge clock);
    ext_wakeup <= 1'b0;
    rd(OFF_POWER_MODE); check("halt exit", 16'h0000, {8'h00, got});
    check("no timebase wake", 16'd1, 16'(wake_seen));
    tally_and_finish();
  end
endmodule
`default_nettype wire
